/* File: adc_ctrl_consts.vh */
// Purpose: constants for the converter control block
// Assumes: bus clock 200 MHz, register port with 4-bit word index
// Notes: all offsets, fields, reset values and timing counts live here
`ifndef ADC_CTRL_CONSTS_VH
`define ADC_CTRL_CONSTS_VH

// ====================================================================
// register offsets (word index on the register port)
`define OFS_SC1 4'h0
`define OFS_CFG 4'h1
`define OFS_RESH 4'h2
`define OFS_RESL 4'h3
`define OFS_PINDIS 4'h4
`define OFS_SC2 4'h5

// ====================================================================
// status/control register 1 fields
`define SC1_CH_LO 0
`define SC1_CH_HI 4
`define SC1_CONT 5
`define SC1_IEN 6
`define SC1_DONE 7
`define CH_OFF 5'h1f

// ====================================================================
// configuration register fields
`define CFG_CLK_LO 0
`define CFG_CLK_HI 1
`define CFG_MODE 2
`define CFG_LSMP 4
`define CFG_DIV_LO 5
`define CFG_DIV_HI 6

// status/control register 2 fields
`define SC2_HWT 6
`define SC2_ACT 7

// ====================================================================
// reset values
`define SC1_RST 8'h1f
`define CFG_RST 8'h00
`define SC2_RST 8'h00
`define PINDIS_RST 16'h0000

// ====================================================================
// timing: converter clocks per phase, bus cycles for wrap-up and startup
`define SAMP_SHORT 8'h03
`define SAMP_LONG 8'h17
`define BITS_8 8'h0c
`define BITS_10 8'h0f
`define FIRST_EXTRA 8'h03
`define BUS_TAIL 3'h5
// asynchronous clock startup: 5 us of 5 ns bus cycles, sized for the counter
`define STARTUP_CYC 13'd1000

`endif

/* File: adc_clk_div.v */
// Purpose: converter clock enable from a selected source and divider
// Assumes: sources are synchronous single-cycle enables or levels
// Notes: produces one-cycle ticks of the divided converter clock
module adc_clk_div
(
   input wire clk,
   input wire rst,
   input wire [1:0] srcSel,
   input wire [1:0] divSel,
   input wire altTick,
   input wire asyncTick,
   output reg tick
);

reg [2:0] divCnt_ff;
reg srcTick;
reg [2:0] divMax;

// ====================================================================
// source select and divide ratio
always @*
begin
   case (srcSel)
      2'h0: srcTick = 1'b1;
      2'h1: srcTick = altTick;
      2'h2: srcTick = altTick;
      default: srcTick = asyncTick;
   endcase
   case (divSel)
      2'h0: divMax = 3'h0;
      2'h1: divMax = 3'h1;
      2'h2: divMax = 3'h3;
      default: divMax = 3'h7;
   endcase
end

// divider counter, tick on terminal count
always @(posedge clk)
begin
   if (rst)
   begin
      divCnt_ff <= 3'h0;
      tick <= 1'b0;
   end
   else
   begin
      tick <= 1'b0;
      if (srcTick)
      begin
         if (divCnt_ff >= divMax)
         begin
            divCnt_ff <= 3'h0;
            tick <= 1'b1;
         end
         else
            divCnt_ff <= divCnt_ff + 3'h1;
      end
   end
end

endmodule

/* File: adc_conversion_control.v */
// Purpose: control for a successive-approximation converter
// Assumes: analog core answers one bit per converter clock via cmpBit
// Notes: register port: address, write data, strobes, read data next cycle
// ====================================================================
// What this block does
// - analog-disabled pin: output high-z, input buffer off, pullup off
// - port read returns zero for analog-disabled pins
// - hardware trigger select set: start on each trigger rising edge
// - trigger edge during a running conversion is ignored
// - continuous hardware mode: only the first edge launches the sequence
// - hardware trigger works with every mode and configuration
// - resolution field selects 10-bit or 8-bit conversion
// - software mode: write to control 1 with channel not all ones starts
// - continuous mode restarts sampling at conversion end, beside the result transfer
// - software continuous: start after control 1 write, repeat until abort
// - hardware continuous: start after trigger, repeat until abort
// - finished result loads into high and low result registers
// - short sample first conversion: 20 or 23 converter clocks plus 5 bus
// - long sample first conversion: 40 or 43 converter clocks plus 5 bus
// - asynchronous clock source adds startup up to 5 us on first conversion
// - later continuous conversions take 17/20 or 37/40 converter clocks
// - converter clock is selected source divided by chosen ratio
// - divide field selects 1, 2, 4 or 8
//
// Design decisions made here: the register offsets and the address-and-strobe port.
`include "adc_ctrl_consts.vh"

module adc_conversion_control
(
   input wire clk,
   input wire rst,
   input wire [3:0] regAddr,
   input wire [7:0] regWrData,
   input wire regWr,
   input wire regRd,
   output reg [7:0] regRdData,
   input wire hwTrigger,
   input wire altClkTick,
   input wire asyncClkTick,
   input wire cmpBit,
   output wire sampleOn,
   output wire [9:0] dacCode,
   output wire [4:0] chanSel,
   input wire [15:0] padIn,
   input wire [15:0] portOut,
   input wire [15:0] portOutEnN,
   input wire [15:0] portPullEn,
   output wire [15:0] padOutEnN,
   output wire [15:0] padPullEn,
   output wire [15:0] padInBufEn,
   output wire [15:0] portRdData,
   output wire convIrq
);

localparam ST_IDLE = 3'h0;
localparam ST_START = 3'h1;
localparam ST_SAMP = 3'h2;
localparam ST_CONV = 3'h3;
localparam ST_TAIL = 3'h4;

reg [7:0] sc1_ff;
reg [7:0] cfg_ff;
reg [7:0] sc2_ff;
reg [15:0] pinDis_ff;
reg [9:0] result_ff;
reg [2:0] state_ff;
reg [2:0] nxt_state;
reg [12:0] cnt_ff;
reg [12:0] nxt_cnt;
reg [9:0] sar_ff;
reg [9:0] nxt_sar;
reg [3:0] bitIdx_ff;
reg [3:0] nxt_bitIdx;
reg [2:0] tailCnt_ff;
reg [9:0] holdRes_ff;
reg convEnd;
reg trigPrev_ff;
reg hwArmed_ff;
reg done_ff;
reg xfer;
wire convTick;
wire trigRise;
wire swStart;
wire hwStart;
wire is10;
wire [7:0] sampLen;
wire [7:0] bitLen;

// ====================================================================
// converter clock generation
adc_clk_div u_div
(
   .clk(clk),
   .rst(rst),
   .srcSel(cfg_ff[`CFG_CLK_HI:`CFG_CLK_LO]),
   .divSel(cfg_ff[`CFG_DIV_HI:`CFG_DIV_LO]),
   .altTick(altClkTick),
   .asyncTick(asyncClkTick),
   .tick(convTick)
);

// ====================================================================
// pin control: analog-disabled pins lose their digital interface
assign padOutEnN = portOutEnN | pinDis_ff;
assign padPullEn = portPullEn & ~pinDis_ff;
assign padInBufEn = ~pinDis_ff;
assign portRdData = padIn & ~pinDis_ff;

// ====================================================================
// start sources
assign is10 = cfg_ff[`CFG_MODE];
assign sampLen = cfg_ff[`CFG_LSMP] ? `SAMP_LONG : `SAMP_SHORT;
assign bitLen = is10 ? `BITS_10 : `BITS_8;
assign trigRise = hwTrigger & ~trigPrev_ff;
// software start on a control 1 write naming a real channel
assign swStart = regWr && (regAddr == `OFS_SC1) && !sc2_ff[`SC2_HWT]
   && (regWrData[`SC1_CH_HI:`SC1_CH_LO] != `CH_OFF);
// hardware edge only when idle and armed; ignored during conversion
assign hwStart = sc2_ff[`SC2_HWT] && trigRise && hwArmed_ff
   && (state_ff == ST_IDLE) && (sc1_ff[`SC1_CH_HI:`SC1_CH_LO] != `CH_OFF);

assign sampleOn = (state_ff == ST_SAMP);
// 8-bit codes drive the top of the trial word
assign dacCode = is10 ? sar_ff : {sar_ff[7:0], 2'h0};
assign chanSel = sc1_ff[`SC1_CH_HI:`SC1_CH_LO];
assign convIrq = done_ff & sc1_ff[`SC1_IEN];

// ====================================================================
// conversion sequencer
always @*
begin
   nxt_state = state_ff;
   nxt_cnt = cnt_ff;
   nxt_sar = sar_ff;
   nxt_bitIdx = bitIdx_ff;
   convEnd = 1'b0;
   // result moves over in the last bus cycle of the wrap-up
   xfer = (tailCnt_ff == 3'h1);
   case (state_ff)
      ST_IDLE:
      begin
         nxt_cnt = 13'h0;
      end
      ST_START:
      begin
         // first conversion: startup on async source, then wait for a tick
         if (cnt_ff != 13'h0)
            nxt_cnt = cnt_ff - 13'h1;
         else if (convTick)
         begin
            // first sample is longer by the first-conversion overhead less the start tick
            nxt_state = ST_SAMP;
            nxt_cnt = {5'h0, sampLen + `FIRST_EXTRA - 8'h01};
         end
      end
      ST_SAMP:
      begin
         if (convTick)
         begin
            if (cnt_ff == 13'h0)
            begin
               nxt_state = ST_CONV;
               nxt_bitIdx = is10 ? 4'h9 : 4'h7;
               nxt_sar = is10 ? 10'h200 : 10'h080;
               nxt_cnt = {5'h0, bitLen};
            end
            else
               nxt_cnt = cnt_ff - 13'h1;
         end
      end
      ST_CONV:
      begin
         // one bit decided per converter clock, overhead clocks after
         if (convTick)
         begin
            nxt_cnt = cnt_ff - 13'h1;
            if (bitIdx_ff != 4'hf)
            begin
               if (!cmpBit)
                  nxt_sar[bitIdx_ff] = 1'b0;
               if (bitIdx_ff != 4'h0)
                  nxt_sar[bitIdx_ff - 4'h1] = 1'b1;
               nxt_bitIdx = bitIdx_ff - 4'h1;
            end
            if (cnt_ff == 13'h0)
            begin
               // wrap-up runs beside the next sample in continuous mode
               convEnd = 1'b1;
               nxt_cnt = {5'h0, sampLen};
               if (sc1_ff[`SC1_CONT])
                  nxt_state = ST_SAMP;
               else
                  nxt_state = ST_TAIL;
            end
         end
      end
      ST_TAIL:
      begin
         // single conversion stays active until the result has moved
         if (xfer)
            nxt_state = ST_IDLE;
      end
      default:
      begin
         nxt_state = ST_IDLE;
      end
   endcase
   // a fresh start (or restart) overrides everything
   if (swStart || hwStart)
   begin
      nxt_state = ST_START;
      nxt_cnt = (cfg_ff[`CFG_CLK_HI:`CFG_CLK_LO] == 2'h3) ?
         `STARTUP_CYC : 13'h0;
      nxt_sar = 10'h000;
   end
   else if (regWr && regAddr == `OFS_SC1)
      nxt_state = ST_IDLE;
end

// ====================================================================
// sequencer registers and trigger arming
always @(posedge clk)
begin
   if (rst)
   begin
      state_ff <= ST_IDLE;
      cnt_ff <= 13'h0;
      sar_ff <= 10'h000;
      bitIdx_ff <= 4'h0;
      trigPrev_ff <= 1'b0;
      hwArmed_ff <= 1'b1;
      tailCnt_ff <= 3'h0;
      holdRes_ff <= 10'h000;
   end
   else
   begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      sar_ff <= nxt_sar;
      bitIdx_ff <= nxt_bitIdx;
      trigPrev_ff <= hwTrigger;
      // bus-clock wrap-up counter; an abort drops the pending result
      if (regWr && regAddr == `OFS_SC1)
         tailCnt_ff <= 3'h0;
      else if (convEnd)
         tailCnt_ff <= `BUS_TAIL;
      else if (tailCnt_ff != 3'h0)
         tailCnt_ff <= tailCnt_ff - 3'h1;
      if (convEnd)
         holdRes_ff <= is10 ? nxt_sar : {2'h0, nxt_sar[7:0]};
      // continuous hardware mode takes only the launching edge
      if (regWr && regAddr == `OFS_SC1)
         hwArmed_ff <= 1'b1;
      else if (hwStart && sc1_ff[`SC1_CONT])
         hwArmed_ff <= 1'b0;
   end
end

// ====================================================================
// register writes, result transfer and done flag
always @(posedge clk)
begin
   if (rst)
   begin
      sc1_ff <= `SC1_RST;
      cfg_ff <= `CFG_RST;
      sc2_ff <= `SC2_RST;
      pinDis_ff <= `PINDIS_RST;
      result_ff <= 10'h000;
      done_ff <= 1'b0;
   end
   else
   begin
      if (regWr)
      begin
         case (regAddr)
            `OFS_SC1: sc1_ff <= {1'b0, regWrData[6:0]};
            `OFS_CFG: cfg_ff <= regWrData;
            `OFS_SC2: sc2_ff <= {1'b0, regWrData[6:0]};
            `OFS_PINDIS: pinDis_ff[7:0] <= regWrData;
            `OFS_RESH: pinDis_ff[15:8] <= regWrData;
            default: ;
         endcase
      end
      // completion is set even in the cycle a control 1 write clears it
      if (regWr && regAddr == `OFS_SC1)
         done_ff <= 1'b0;
      if (regRd && regAddr == `OFS_RESL)
         done_ff <= 1'b0;
      if (xfer)
      begin
         result_ff <= holdRes_ff;
         done_ff <= 1'b1;
      end
   end
end

// ====================================================================
// read data, one cycle after the read strobe
always @(posedge clk)
begin
   if (rst)
   begin
      regRdData <= 8'h00;
   end
   else
   begin
      regRdData <= 8'h00;
      if (regRd)
      begin
         case (regAddr)
            `OFS_SC1: regRdData <= {done_ff, sc1_ff[6:0]};
            `OFS_CFG: regRdData <= cfg_ff;
            `OFS_SC2: regRdData <= {(state_ff != ST_IDLE), sc2_ff[6:0]};
            `OFS_RESH: regRdData <= {6'h00, result_ff[9:8]};
            `OFS_RESL: regRdData <= result_ff[7:0];
            `OFS_PINDIS: regRdData <= pinDis_ff[7:0];
            default: regRdData <= 8'h00;
         endcase
      end
   end
end

endmodule

/* File: adc_ctrl_assertions.sv */
// Purpose: port-level checks for the converter control block
// Assumes: bound to the top module, single bus clock domain
// Notes: hardware select is tracked from control 2 writes
`include "adc_ctrl_consts.vh"

// ==========================================================
// checker
module adc_ctrl_assertions
(
   input wire clk,
   input wire rst,
   input wire [3:0] regAddr,
   input wire [7:0] regWrData,
   input wire regWr,
   input wire [15:0] padIn,
   input wire [15:0] padOutEnN,
   input wire [15:0] padPullEn,
   input wire [15:0] padInBufEn,
   input wire [15:0] portRdData,
   input wire sampleOn,
   input wire [4:0] chanSel,
   input wire convIrq
);
   timeunit 1ns;
   timeprecision 1ps;
   logic hwSel_ff;
   wire sc1Wr = regWr && regAddr == `OFS_SC1;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // shadow of the hardware trigger select
   always @(posedge clk)
   begin
      if (rst)
         hwSel_ff <= 1'b0;
      else if (regWr && regAddr == `OFS_SC2)
         hwSel_ff <= regWrData[`SC2_HWT];
   end
   // cycles since a starting control 1 write, until sampling shows
   logic [10:0] waitCnt_ff;
   always @(posedge clk)
   begin
      if (rst)
         waitCnt_ff <= 11'h000;
      else if (sc1Wr)
         waitCnt_ff <= (regWrData[4:0] != `CH_OFF && !hwSel_ff) ? 11'h001 : 11'h000;
      else if (sampleOn)
         waitCnt_ff <= 11'h000;
      else if (waitCnt_ff != 11'h000)
         waitCnt_ff <= waitCnt_ff + 11'h001;
   end
   property p_outOff; (~padInBufEn & ~padOutEnN) == 16'h0000; endproperty
   a_outOff: assert property (p_outOff) else $error("driver on at disabled pin");
   property p_pullOff; (~padInBufEn & padPullEn) == 16'h0000; endproperty
   a_pullOff: assert property (p_pullOff) else $error("pullup on at disabled pin");
   property p_portZero; portRdData == (padIn & padInBufEn); endproperty
   a_portZero: assert property (p_portZero) else $error("port read wrong");
   property p_inBuf;
      regWr && regAddr == `OFS_PINDIS |=> padInBufEn[7:0] == ~$past(regWrData);
   endproperty
   a_inBuf: assert property (p_inBuf) else $error("input buffer not off");
   property p_chan; sc1Wr |=> chanSel == $past(regWrData[4:0]); endproperty
   a_chan: assert property (p_chan) else $error("channel not taken");
   property p_irqClr; sc1Wr && !regWrData[`SC1_IEN] |=> !convIrq; endproperty
   a_irqClr: assert property (p_irqClr) else $error("request while disabled");
   property p_abort; sc1Wr && regWrData[4:0] == `CH_OFF |=> !sampleOn [*2]; endproperty
   a_abort: assert property (p_abort) else $error("sampling after abort");
   property p_start; waitCnt_ff <= 11'd1100; endproperty
   a_start: assert property (p_start) else $error("no start after write");
endmodule

/* File: adc_analog_model.sv */
// Purpose: analog side: track-and-hold input and comparator
// Assumes: input is tracked while sampleOn is high and held while it is low
// Notes: cmpBit keeps the trial bit when the code is not above the input
module adc_analog_model
(
   input wire clk,
   input wire sampleOn,
   input wire [9:0] dacCode,
   input wire [9:0] level,
   output logic cmpBit
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [9:0] held_ff = 10'h000;
   // track the input during the sample phase, hold it after
   always @(posedge clk)
   begin
      if (sampleOn)
         held_ff <= level;
   end
   // comparator against the trial code
   assign cmpBit = dacCode <= held_ff;
endmodule

/* File: adc_conversion_control_tb.sv */
// Purpose: register-level tests of the converter control block
// Assumes: bus clock 200 MHz, alternate sources tick every other cycle
// Notes: conversion times counted in bus cycles after the start
`include "adc_ctrl_consts.vh"

// ==========================================================
// bench
module adc_conversion_control_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, cmpBit, sampleOn, convIrq;
   logic rst = 1, regWr = 0, regRd = 0, hwTrigger = 0, altClkTick = 0, asyncClkTick = 1;
   logic [3:0] regAddr = 0;
   logic [7:0] regWrData = 0, regRdData;
   logic [9:0] dacCode, level = 10'h2b7;
   logic [4:0] chanSel;
   logic [15:0] padIn = 16'hffff, portOut = 16'h1234, portOutEnN = 0, portPullEn = 16'hffff;
   logic [15:0] padOutEnN, padPullEn, padInBufEn, portRdData, n, n10;
   int errors = 0, compares = 0, cyc = 0, i;
   adc_conversion_control adc_conversion_control_i (.clk, .rst, .regAddr, .regWrData,
      .regWr, .regRd, .regRdData, .hwTrigger, .altClkTick, .asyncClkTick, .cmpBit,
      .sampleOn, .dacCode, .chanSel, .padIn, .portOut, .portOutEnN, .portPullEn,
      .padOutEnN, .padPullEn, .padInBufEn, .portRdData, .convIrq);
   adc_analog_model adc_analog_model_i (.clk, .sampleOn, .dacCode, .level, .cmpBit);
   initial
   begin
      clk = 0;
      forever #2.5 clk = ~clk;
   end
   // half-rate alternate clock sources, and a hang limit
   always @(posedge clk)
   begin
      altClkTick <= ~altClkTick;
      asyncClkTick <= altClkTick;
      cyc++;
      if (cyc == 40000)
      begin
         errors++;
         close_out();
      end
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp)
      begin
         errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      regWr <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge clk);
      regWr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge clk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRd <= 1'b0;
      #1;
   endtask
   task automatic rc(input logic [3:0] a, input logic [7:0] exp);
      rd(a);
      chk(regRdData, exp);
   endtask
   // bus cycles until the completion request shows
   task automatic waitIrq();
      n = 0;
      while (convIrq !== 1'b1 && n < 1200)
      begin
         @(posedge clk);
         #1 n++;
      end
   endtask
   // trigger pulse three cycles wide
   task automatic trig();
      @(posedge clk);
      hwTrigger <= 1'b1;
      repeat (3) @(posedge clk);
      hwTrigger <= 1'b0;
   endtask
   // software single conversion with result readback
   task automatic conv(input logic [7:0] cfg);
      wr(`OFS_CFG, cfg);
      wr(`OFS_SC1, 8'h43);
      waitIrq();
      if (cfg[`CFG_MODE])
      begin
         rc(`OFS_RESH, {6'h00, level[9:8]});
         rc(`OFS_RESL, level[7:0]);
      end
      else
         rd(`OFS_RESL);
      chk(convIrq, 1'b0);
   endtask
   task automatic close_out();
      if (errors == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial
   begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      rc(`OFS_SC1, `SC1_RST);
      rc(`OFS_CFG, `CFG_RST);
      rc(4'h6, 8'h00);
      chk(padInBufEn, 16'hffff);
      wr(`OFS_PINDIS, 8'h5a);
      wr(`OFS_RESH, 8'hc3);
      #1 chk(padOutEnN, portOutEnN | 16'hc35a);
      chk(padPullEn, portPullEn & 16'h3ca5);
      chk(portRdData, padIn & 16'h3ca5);
      // every divide ratio at 10-bit short sample
      for (i = 0; i < 4; i++)
      begin
         conv({1'b0, i[1:0], 5'h04});
         chk(n <= (23 << i) + 8 && n >= (20 << i), 1'b1);
         if (i == 0)
            n10 = n;
      end
      conv(8'h00);
      chk(n, n10 - 3);
      rc(`OFS_RESL, level[9:2]);
      conv(8'h14);
      chk(n, n10 + 20);
      conv(8'h05);
      chk(n <= 54 && n >= 40, 1'b1);
      conv(8'h07);
      chk(n <= `STARTUP_CYC + 56 && n >= `STARTUP_CYC, 1'b1);
      // restart mid-conversion, then abort
      wr(`OFS_CFG, 8'h04);
      wr(`OFS_SC1, 8'h43);
      repeat (10) @(posedge clk);
      wr(`OFS_SC1, 8'h43);
      waitIrq();
      chk(n, n10);
      wr(`OFS_SC1, 8'h43);
      repeat (10) @(posedge clk);
      wr(`OFS_SC1, 8'h5f);
      repeat (60) @(posedge clk);
      chk(convIrq, 1'b0);
      // hardware trigger: no start on write, edges during a run ignored
      wr(`OFS_SC2, 8'h40);
      wr(`OFS_SC1, 8'h43);
      repeat (60) @(posedge clk);
      chk(convIrq, 1'b0);
      trig();
      waitIrq();
      chk(n <= 28, 1'b1);
      rd(`OFS_RESL);
      trig();
      repeat (8) @(posedge clk);
      trig();
      waitIrq();
      rd(`OFS_RESL);
      repeat (60) @(posedge clk);
      chk(convIrq, 1'b0);
      conv(8'h10);
      chk(n, 16'd1200);
      trig();
      waitIrq();
      chk(n <= 45, 1'b1);
      rd(`OFS_RESL);
      // continuous runs, hardware then software launched
      for (i = 0; i < 2; i++)
      begin
         wr(`OFS_CFG, 8'h04);
         wr(`OFS_SC2, i[0] ? 8'h00 : 8'h40);
         wr(`OFS_SC1, 8'h63);
         if (i == 0)
            trig();
         waitIrq();
         rd(`OFS_RESL);
         trig();
         waitIrq();
         chk(n <= 28 && n > 0, 1'b1);
         // next result 20 converter clocks on; read and trigger used 6 of them
         chk(n, 16'd20 - 16'd6);
         wr(`OFS_SC1, 8'h5f);
         repeat (60) @(posedge clk);
         chk(convIrq, 1'b0);
      end
      close_out();
   end
endmodule

bind adc_conversion_control adc_ctrl_assertions adc_ctrl_assertions_i (.clk, .rst,
   .regAddr, .regWrData, .regWr, .padIn, .padOutEnN, .padPullEn, .padInBufEn,
   .portRdData, .sampleOn, .chanSel, .convIrq);
